// >>> common/qss_pkg.sv
// Purpose: Shared constants for the quad switch status and defaults block
// Assumes: One 25 MHz clock, synchronous active-low reset
// Notes:   Selector codes and reset defaults live here only
package qss_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned CH_N     = 4;
  localparam int unsigned SEL_W    = 5;
  localparam int unsigned OCLO_W   = 3;
  localparam int unsigned BLANK_W  = 2;
  localparam int unsigned WDP_W    = 2;
  localparam int unsigned WDCNT_W  = 24;

  // ---------------------------------------------------------------
  // Readback select codes
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_PINS_FS  = 5'h06;
  localparam logic [SEL_W-1:0] SEL_PINS_IN  = 5'h0E;
  localparam logic [SEL_W-1:0] SEL_OT_LATCH = 5'h0F;
  localparam logic [SEL_W-1:0] SEL_RST      = 5'h00;

  // ---------------------------------------------------------------
  // Reset defaults
  // ---------------------------------------------------------------
  localparam logic [OCLO_W-1:0]  OCLO_RST   = 3'h0;
  localparam logic               OCHI_RST   = 1'h0;
  localparam logic [BLANK_W-1:0] BLANK_RST  = 2'h0;
  localparam logic [WDP_W-1:0]   WDP_RST    = 2'h0;
  localparam logic               PROT_DIS_RST = 1'h0;
  localparam logic               CSNS_EN_RST  = 1'h0;
  localparam logic               CSNS_HI_RST  = 1'h0;
  localparam logic               FAST_SR_RST  = 1'h0;
  localparam logic [CH_N-1:0]    OT_LATCH_RST = 4'hF;

  // ---------------------------------------------------------------
  // Watchdog timing (clock 25 MHz)
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 25000;
  localparam int unsigned WD_PERIOD0_MS = 10;
  localparam int unsigned WD_PERIOD0_CYC = WD_PERIOD0_MS * CLK_KHZ;

endpackage

// >>> rtl/qss_switch_status.sv
// Purpose: Readback selection, host-less control, fault pin and config defaults
// Assumes: SPI framing and decoding done outside; strobes are one-cycle pulses
// Notes:   Unmapped readback codes return zero in the low nibble
`timescale 1ns/1ns
`default_nettype none
module qss_switch_status
  import qss_pkg::*;
#(
  parameter int unsigned WD_PERIOD0 = WD_PERIOD0_CYC,
  parameter int unsigned WD_PERIOD1 = 2 * WD_PERIOD0_CYC,
  parameter int unsigned WD_PERIOD2 = 4 * WD_PERIOD0_CYC,
  parameter int unsigned WD_PERIOD3 = 8 * WD_PERIOD0_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Decoded SPI commands
  input  wire logic                spi_frame,
  input  wire logic                sel_wr,
  input  wire logic [SEL_W-1:0]    sel_code,
  input  wire logic                out_wr,
  input  wire logic [CH_N-1:0]     out_on,
  input  wire logic                prot_wr,
  input  wire logic                ov_dis,
  input  wire logic                uv_dis,
  input  wire logic [1:0]          ot_latch_lo,
  input  wire logic                oc_wr,
  input  wire logic [OCLO_W-1:0]   oc_low_sel,
  input  wire logic                oc_high_sel,
  input  wire logic [BLANK_W-1:0]  blank_sel,
  input  wire logic                oc_dis,
  input  wire logic                wd_wr,
  input  wire logic [WDP_W-1:0]    wd_period_sel,
  input  wire logic [1:0]          ot_latch_hi,
  input  wire logic                misc_wr,
  input  wire logic                csns_en,
  input  wire logic                csns_ratio_high,
  input  wire logic                fast_slew,
  // Device pins
  input  wire logic [CH_N-1:0]     direct_input_pins,
  input  wire logic                failsafe_config_input,
  input  wire logic                failsafe_hs2,
  input  wire logic                failsafe_hs0,
  input  wire logic                wake_pin,
  // Detected fault conditions
  input  wire logic [CH_N-1:0]     ot_det,
  input  wire logic [CH_N-1:0]     oc_det,
  input  wire logic [CH_N-1:0]     load_fault_det,
  input  wire logic                ov_det,
  input  wire logic                uv_det,
  // Switch outputs and fault pin
  output logic [CH_N-1:0]          switch_outputs,
  output logic                     fault_status_pin_n,
  // Status readback
  output logic [SEL_W-1:0]         readback_select_code,
  output logic [3:0]               readback_low_nibble,
  output logic                     watchdog_expired_flag,
  // Active configuration
  output logic                     spi_mode,
  output logic                     ov_prot_en,
  output logic                     uv_prot_en,
  output logic                     oc_prot_en,
  output logic [OCLO_W-1:0]        oc_low_level,
  output logic                     oc_high_level,
  output logic [BLANK_W-1:0]       blank_time,
  output logic [WDP_W-1:0]         wd_period,
  output logic                     csns_enable,
  output logic                     csns_ratio,
  output logic                     fast_slew_mode
);

  typedef struct packed {
    logic                spi;
    logic [SEL_W-1:0]    sel;
    logic [3:0]          nib;
    logic [CH_N-1:0]     spi_on;
    logic                ov_dis;
    logic                uv_dis;
    logic                oc_dis;
    logic [CH_N-1:0]     ot_latch;
    logic [CH_N-1:0]     ot_hold;
    logic [OCLO_W-1:0]   oclo;
    logic                ochi;
    logic [BLANK_W-1:0]  blank;
    logic [WDP_W-1:0]    wdp;
    logic                csns;
    logic                csns_hi;
    logic                fast;
    logic [WDCNT_W-1:0]  wd_cnt;
    logic                expired;
    logic [CH_N-1:0]     outs;
    logic                fs_n;
  } qss_state_t;

  qss_state_t st_q;
  qss_state_t st_d;

  logic                wd_en;
  logic [WDCNT_W-1:0]  wd_limit;
  logic [CH_N-1:0]     cmd_on;
  logic [CH_N-1:0]     trip;
  logic                any_cfg;

  // ---------------------------------------------------------------
  // Watchdog limit
  // ---------------------------------------------------------------
  // period select
  always_comb begin
    case (st_q.wdp)
      2'h0:    wd_limit = WDCNT_W'(WD_PERIOD0);
      2'h1:    wd_limit = WDCNT_W'(WD_PERIOD1);
      2'h2:    wd_limit = WDCNT_W'(WD_PERIOD2);
      2'h3:    wd_limit = WDCNT_W'(WD_PERIOD3);
      default: wd_limit = WDCNT_W'(WD_PERIOD0);
    endcase
  end

  assign wd_en   = failsafe_config_input;
  assign any_cfg = out_wr | prot_wr | oc_wr | wd_wr | misc_wr | sel_wr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (any_cfg) begin
      st_d.spi = 1'b1;
    end
    if (sel_wr) begin
      st_d.sel = sel_code;
    end
    if (out_wr) begin
      st_d.spi_on = out_on;
    end
    if (prot_wr) begin
      st_d.ov_dis          = ov_dis;
      st_d.uv_dis          = uv_dis;
      st_d.ot_latch[1:0]   = ot_latch_lo;
    end
    if (oc_wr) begin
      st_d.oclo   = oc_low_sel;
      st_d.ochi   = oc_high_sel;
      st_d.blank  = blank_sel;
      st_d.oc_dis = oc_dis;
    end
    if (wd_wr) begin
      st_d.wdp           = wd_period_sel;
      st_d.ot_latch[3:2] = ot_latch_hi;
    end
    if (misc_wr) begin
      st_d.csns    = csns_en;
      st_d.csns_hi = csns_ratio_high;
      st_d.fast    = fast_slew;
    end

    if (!wd_en || spi_frame) begin
      st_d.wd_cnt = '0;
    end else if (!st_q.expired) begin
      if (st_q.wd_cnt >= wd_limit - 1'b1) begin
        st_d.expired = 1'b1;
      end else begin
        st_d.wd_cnt = st_q.wd_cnt + 1'b1;
      end
    end

    // direct inputs control until watchdog expiry; SPI adds once used
    cmd_on = direct_input_pins | (st_q.spi ? st_q.spi_on : '0);
    if (st_q.expired) begin
      cmd_on = {1'b0, failsafe_hs2, 1'b0, failsafe_hs0};
    end

    // latched overtemperature cleared by off command, set wins
    st_d.ot_hold = (st_q.ot_hold & cmd_on) | (ot_det & st_q.ot_latch);
    trip = ot_det | st_d.ot_hold
         | (st_q.oc_dis ? '0 : oc_det)
         | ((ov_det && !st_q.ov_dis) ? '1 : '0)
         | ((uv_det && !st_q.uv_dis) ? '1 : '0);
    st_d.outs = cmd_on & ~trip;

    // fault pin low on any trip or load fault
    st_d.fs_n = ~(|(trip | load_fault_det));

    case (st_q.sel)
      SEL_PINS_FS:  st_d.nib = {failsafe_hs2, failsafe_hs0, wd_en, wake_pin};
      SEL_PINS_IN:  st_d.nib = direct_input_pins;
      SEL_OT_LATCH: st_d.nib = {st_q.ot_latch[3:2], 2'b00};
      default:      st_d.nib = 4'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // protections on, sense off, slow slew; first settings
      st_q.spi      <= 1'b0;
      st_q.sel      <= SEL_RST;
      st_q.nib      <= 4'h0;
      st_q.spi_on   <= '0;
      st_q.ov_dis   <= PROT_DIS_RST;
      st_q.uv_dis   <= PROT_DIS_RST;
      st_q.oc_dis   <= PROT_DIS_RST;
      st_q.ot_latch <= OT_LATCH_RST;
      st_q.ot_hold  <= '0;
      st_q.oclo     <= OCLO_RST;
      st_q.ochi     <= OCHI_RST;
      st_q.blank    <= BLANK_RST;
      st_q.wdp      <= WDP_RST;
      st_q.csns     <= CSNS_EN_RST;
      st_q.csns_hi  <= CSNS_HI_RST;
      st_q.fast     <= FAST_SR_RST;
      st_q.wd_cnt   <= '0;
      st_q.expired  <= 1'b0;
      st_q.outs     <= '0;
      st_q.fs_n     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign switch_outputs        = st_q.outs;
  assign fault_status_pin_n    = st_q.fs_n;
  assign readback_select_code  = st_q.sel;
  assign readback_low_nibble   = st_q.nib;
  assign watchdog_expired_flag = st_q.expired;
  assign spi_mode              = st_q.spi;
  assign ov_prot_en            = ~st_q.ov_dis;
  assign uv_prot_en            = ~st_q.uv_dis;
  assign oc_prot_en            = ~st_q.oc_dis;
  assign oc_low_level          = st_q.oclo;
  assign oc_high_level         = st_q.ochi;
  assign blank_time            = st_q.blank;
  assign wd_period             = st_q.wdp;
  assign csns_enable           = st_q.csns & st_q.spi;
  assign csns_ratio            = st_q.csns_hi;
  assign fast_slew_mode        = st_q.fast;

endmodule
`default_nettype wire

// >>> verif/qss_host.sv
// Purpose: Host stand-in that serves the watchdog with frames
// Assumes: Frames are one-cycle pulses, every fourth cycle
// Notes:   Frames stop while keep is low
`timescale 1ns/1ns
`default_nettype none
module qss_host (
  // Clock and control
  input  wire logic clk,
  input  wire logic keep,
  // Frame strobe
  output logic      spi_frame
);
  logic [1:0] cnt = 2'h0;
  initial spi_frame = 1'b0;
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    spi_frame <= #2 keep && (cnt == 2'h0);
  end
endmodule
`default_nettype wire

// >>> verif/qss_switch_status_props.sv
// Purpose: Port-level checks of readback and host-less behaviour
// Assumes: Watches only the top module ports
// Notes:   Bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module qss_switch_status_props
  import qss_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             rstn,
  // Inputs watched
  input wire logic             sel_wr,
  input wire logic [SEL_W-1:0] sel_code,
  input wire logic [CH_N-1:0]  direct_input_pins,
  input wire logic             failsafe_config_input,
  input wire logic             failsafe_hs2,
  input wire logic             failsafe_hs0,
  input wire logic             wake_pin,
  input wire logic [CH_N-1:0]  load_fault_det,
  // Outputs watched
  input wire logic [CH_N-1:0]  switch_outputs,
  input wire logic             fault_status_pin_n,
  input wire logic [SEL_W-1:0] readback_select_code,
  input wire logic [3:0]       readback_low_nibble,
  input wire logic             watchdog_expired_flag,
  input wire logic             spi_mode,
  input wire logic             ov_prot_en,
  input wire logic             uv_prot_en,
  input wire logic             oc_prot_en,
  input wire logic             csns_enable,
  input wire logic             fast_slew_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_sel_load:
    assert property (sel_wr |=> readback_select_code == $past(sel_code)) else $error("select code not taken");
  chk_sel_hold:
    assert property (!sel_wr |=> $stable(readback_select_code)) else $error("select code moved");
  chk_pins_in:
    assert property (readback_select_code == SEL_PINS_IN |=> readback_low_nibble == $past(direct_input_pins))
      else $error("input pin readback wrong");
  chk_pins_fs:
    assert property (readback_select_code == SEL_PINS_FS |=> readback_low_nibble ==
      {$past(failsafe_hs2), $past(failsafe_hs0), $past(failsafe_config_input), $past(wake_pin)})
      else $error("fail-safe readback wrong");
  chk_ot_low:
    assert property (readback_select_code == SEL_OT_LATCH |=> readback_low_nibble[1:0] == 2'h0)
      else $error("latch readback low bits set");
  chk_fault_pin:
    assert property (|load_fault_det |=> !fault_status_pin_n) else $error("fault pin not low");
  chk_hostless_cfg:
    assert property (!spi_mode |-> ov_prot_en && uv_prot_en && oc_prot_en && !csns_enable && !fast_slew_mode)
      else $error("host-less config not default");
  chk_direct_ctrl:
    assert property (!spi_mode && !watchdog_expired_flag ##1 fault_status_pin_n && !watchdog_expired_flag
      |-> switch_outputs == $past(direct_input_pins)) else $error("direct input control wrong");
  chk_wd_sticky:
    assert property (watchdog_expired_flag |=> watchdog_expired_flag) else $error("expired flag dropped");
  chk_failsafe_out:
    assert property (watchdog_expired_flag [*2] |-> !switch_outputs[3] && !switch_outputs[1])
      else $error("fail-safe outputs wrong");
  cover property (readback_select_code == SEL_PINS_IN);
  cover property ($rose(watchdog_expired_flag));
  cover property ($fell(fault_status_pin_n));
endmodule
bind qss_switch_status qss_switch_status_props u_props (.*);
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Directed regression of readback, host-less control and defaults
// Assumes: Watchdog periods shortened to 8..64 cycles
// Notes:   Inputs move 2 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import qss_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, keep = 1'b0, spi_frame, sel_wr = 1'b0, out_wr = 1'b0, prot_wr = 1'b0;
  logic ov_dis = 1'b0, uv_dis = 1'b0, oc_wr = 1'b0, oc_high_sel = 1'b0, oc_dis = 1'b0, wd_wr = 1'b0;
  logic misc_wr = 1'b0, csns_en = 1'b0, csns_ratio_high = 1'b0, fast_slew = 1'b0, wake_pin = 1'b0;
  logic failsafe_config_input = 1'b0, failsafe_hs2 = 1'b0, failsafe_hs0 = 1'b0, ov_det = 1'b0, uv_det = 1'b0;
  logic [4:0] sel_code = 5'h00, readback_select_code;
  logic [3:0] out_on = 4'h0, direct_input_pins = 4'h0, ot_det = 4'h0, oc_det = 4'h0, load_fault_det = 4'h0;
  logic [3:0] switch_outputs, readback_low_nibble;
  logic [2:0] oc_low_sel = 3'h0, oc_low_level;
  logic [1:0] ot_latch_lo = 2'h0, ot_latch_hi = 2'h0, blank_sel = 2'h0, wd_period_sel = 2'h0, blank_time, wd_period;
  logic fault_status_pin_n, watchdog_expired_flag, spi_mode, ov_prot_en, uv_prot_en, oc_prot_en;
  logic oc_high_level, csns_enable, csns_ratio, fast_slew_mode;
  int fail_count = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  qss_host u_host (.clk(clk), .keep(keep), .spi_frame(spi_frame));
  qss_switch_status #(.WD_PERIOD0(8), .WD_PERIOD1(16), .WD_PERIOD2(32), .WD_PERIOD3(64)) DUT (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic cmp(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sel(input logic [4:0] code);
    sel_code = code;
    sel_wr = 1'b1;
    tick(1);
    sel_wr = 1'b0;
    tick(2);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Run takes under 1000 cycles
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    tick(12);
    rstn = 1'b1;
    tick(1);
    cmp("prot", {5'h00, ov_prot_en, uv_prot_en, oc_prot_en}, 8'h07);
    cmp("levels", {oc_low_level, oc_high_level, blank_time, wd_period}, 8'h00);
    cmp("misc", {4'h0, spi_mode, csns_enable, fast_slew_mode, watchdog_expired_flag}, 8'h00);
    $display("Test defaults finished");
    direct_input_pins = 4'hA; // fail-safe input tied low
    tick(2);
    cmp("outs", {4'h0, switch_outputs}, 8'h0A);
    ov_det = 1'b1;
    tick(2);
    cmp("ov outs", {4'h0, switch_outputs}, 8'h00);
    cmp("ov fs", {7'h00, fault_status_pin_n}, 8'h00);
    ov_det = 1'b0;
    load_fault_det = 4'h1;
    tick(2);
    cmp("load fs", {7'h00, fault_status_pin_n}, 8'h00);
    load_fault_det = 4'h0;
    tick(2);
    cmp("clear fs", {7'h00, fault_status_pin_n}, 8'h01);
    ot_det = 4'h2;
    tick(2);
    cmp("ot on", {4'h0, switch_outputs}, 8'h08);
    ot_det = 4'h0;
    tick(2);
    cmp("ot held", {4'h0, switch_outputs}, 8'h08);
    cmp("ot fs", {7'h00, fault_status_pin_n}, 8'h00);
    direct_input_pins = 4'h8;
    tick(2);
    direct_input_pins = 4'hA;
    oc_det = 4'h8;
    tick(2);
    cmp("oc trip", {4'h0, switch_outputs}, 8'h02);
    {oc_det, uv_det} = 5'h01;
    tick(2);
    cmp("uv outs", {4'h0, switch_outputs}, 8'h00);
    uv_det = 1'b0;
    tick(2);
    $display("Test hostless finished");
    failsafe_hs2 = 1'b1;
    wake_pin = 1'b1;
    sel(SEL_PINS_FS);
    cmp("nib 06", {4'h0, readback_low_nibble}, 8'h09);
    sel(SEL_PINS_IN);
    cmp("nib 0E", {4'h0, readback_low_nibble}, 8'h0A);
    direct_input_pins = 4'h5;
    tick(2);
    cmp("nib held", {4'h0, readback_low_nibble}, 8'h05);
    sel(SEL_OT_LATCH);
    cmp("nib 0F", {4'h0, readback_low_nibble}, 8'h0C);
    sel(5'h1F);
    cmp("nib 1F", {4'h0, readback_low_nibble}, 8'h00);
    $display("Test readback finished");
    {oc_low_sel, oc_high_sel, oc_dis, wd_period_sel, ot_latch_hi} = {3'h7, 1'b1, 1'b1, 2'h3, 2'h1};
    {csns_en, csns_ratio_high, fast_slew, ov_dis, uv_dis} = 5'h1F;
    {oc_wr, wd_wr, misc_wr, prot_wr} = 4'hF;
    tick(1);
    {oc_wr, wd_wr, misc_wr, prot_wr} = 4'h0;
    tick(1);
    cmp("prot", {5'h00, ov_prot_en, uv_prot_en, oc_prot_en}, 8'h00);
    cmp("levels", {oc_low_level, oc_high_level, blank_time, wd_period}, 8'hF3);
    cmp("misc", {5'h00, csns_enable, csns_ratio, fast_slew_mode}, 8'h07);
    sel(SEL_OT_LATCH);
    cmp("nib 0F", {4'h0, readback_low_nibble}, 8'h04);
    {ov_det, uv_det, oc_det} = 6'h3F;
    tick(2);
    cmp("ov off", {4'h0, switch_outputs}, 8'h05);
    {ov_det, uv_det, oc_det} = 6'h00;
    out_on = 4'hA;
    out_wr = 1'b1;
    tick(1);
    out_wr = 1'b0;
    tick(1);
    cmp("spi outs", {4'h0, switch_outputs}, 8'h0F);
    ot_det = 4'hC;
    tick(2);
    cmp("ot mixed", {4'h0, switch_outputs}, 8'h03);
    ot_det = 4'h0;
    tick(2);
    cmp("ot unlatch", {4'h0, switch_outputs}, 8'h0B);
    cmp("ot latch fs", {7'h00, fault_status_pin_n}, 8'h00);
    direct_input_pins = 4'h1;
    tick(2);
    cmp("ot cleared", {4'h0, switch_outputs}, 8'h0B);
    cmp("ot clr fs", {7'h00, fault_status_pin_n}, 8'h01);
    $display("Test config finished");
    keep = 1'b1;
    failsafe_config_input = 1'b1;
    tick(100);
    cmp("wd served", {7'h00, watchdog_expired_flag}, 8'h00);
    keep = 1'b0;
    tick(90);
    cmp("wd expired", {7'h00, watchdog_expired_flag}, 8'h01);
    cmp("fs outs", {4'h0, switch_outputs}, 8'h04);
    $display("Test watchdog finished");
    summarize();
  end
endmodule
`default_nettype wire
